// ### include/dram_cmd_pkg.sv
// shared codes, types and reset values of the command decoder
`default_nettype none
package dram_cmd_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int NUM_BANKS = 8;
	localparam int BANK_W    = 3;
	localparam int ROW_W     = 16;
	localparam int COL_W     = 10;
	localparam int LINES_W   = 6;
	localparam int CODE_W    = 7;
	localparam int INDEX_W   = 6;

	// ----------------------------------------------------------------
	// first-half codes, value bit n is line n
	// ----------------------------------------------------------------
	localparam logic [4:0] CODE_MULTI        = 5'h00;
	localparam logic [4:0] CODE_PRECHARGE    = 5'h10;
	localparam logic [4:0] CODE_REFRESH      = 5'h08;
	localparam logic [4:0] CODE_SR_ENTER     = 5'h18;
	localparam logic [4:0] CODE_WRITE        = 5'h04;
	localparam logic [4:0] CODE_SR_EXIT      = 5'h14;
	localparam logic [4:0] CODE_MASK_WRITE   = 5'h0C;
	localparam logic [4:0] CODE_READ         = 5'h02;
	localparam logic [4:0] CODE_COLUMN       = 5'h12;
	localparam logic [4:0] CODE_MODE_WRITE1  = 5'h06;
	localparam logic [4:0] CODE_MODE_WRITE2  = 5'h16;
	localparam logic [4:0] CODE_MODE_READ    = 5'h0E;
	localparam logic [1:0] CODE_ACTIVATE1    = 2'h1;
	localparam logic [1:0] CODE_ACTIVATE2    = 2'h3;

	// ----------------------------------------------------------------
	// timing counts
	// ----------------------------------------------------------------
	localparam logic [1:0] GUARD_SLOTS = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_NONE, CMD_MULTI, CMD_PRECHARGE, CMD_REFRESH,
		CMD_SR_ENTER, CMD_SR_EXIT, CMD_WRITE, CMD_MASK_WRITE,
		CMD_READ, CMD_COLUMN, CMD_MODE_WRITE1, CMD_MODE_WRITE2,
		CMD_MODE_READ, CMD_ACTIVATE1, CMD_ACTIVATE2, CMD_UNUSED_CODE
	} cmd_kind_type;

	typedef enum logic [1:0] {
		PH_FIRST  = 2'b01,
		PH_SECOND = 2'b10
	} phase_type;

	typedef enum logic [3:0] {
		WAIT_NONE   = 4'b0001,
		WAIT_COLUMN = 4'b0010,
		WAIT_ACT2   = 4'b0100,
		WAIT_MODE2  = 4'b1000
	} wait_type;

	typedef struct packed {
		cmd_kind_type         kind;
		logic [BANK_W-1:0]    target_group_index;
		logic [NUM_BANKS-1:0] bank_mask;
		logic                 every_bank_flag;
		logic [ROW_W-1:0]     row_bits;
		logic [COL_W-1:0]     column;
		logic                 burst_size_flag;
		logic                 auto_close_flag;
		logic [7:0]           payload_bits;
		logic [INDEX_W-1:0]   reg_index_bits;
	} decoded_type;

	typedef struct packed {
		phase_type            phase;
		logic [LINES_W-1:0]   first_lines;
		wait_type             wait_for;
		decoded_type          pend;
		logic [1:0]           guard_left;
		logic                 illegal;
		logic                 out_valid;
		decoded_type          out;
	} state_type;

	localparam decoded_type DECODED_RESET = '0;
	localparam state_type STATE_RESET = '{
		phase:       PH_FIRST,
		first_lines: 6'h00,
		wait_for:    WAIT_NONE,
		pend:        DECODED_RESET,
		guard_left:  2'h0,
		illegal:     1'b0,
		out_valid:   1'b0,
		out:         DECODED_RESET
	};

endpackage
`default_nettype wire

// ### hw/cmd_classify.sv
// classifier of the first-half line pattern
`timescale 1ns/1ns
`default_nettype none
module cmd_classify (
	input  wire logic [5:0]                  first_lines_i, // lines at first edge
	output var  dram_cmd_pkg::cmd_kind_type  kind_o         // command kind
);
	import dram_cmd_pkg::*;

	always_comb begin
		kind_o = CMD_UNUSED_CODE;
		if (first_lines_i[1:0] == CODE_ACTIVATE1) begin
			kind_o = CMD_ACTIVATE1;
		end else if (first_lines_i[1:0] == CODE_ACTIVATE2) begin
			kind_o = CMD_ACTIVATE2;
		end else begin
			case (first_lines_i[4:0])
				CODE_MULTI:       kind_o = CMD_MULTI;
				CODE_PRECHARGE:   kind_o = CMD_PRECHARGE;
				CODE_REFRESH:     kind_o = CMD_REFRESH;
				CODE_SR_ENTER:    kind_o = CMD_SR_ENTER;
				CODE_WRITE:       kind_o = CMD_WRITE;
				CODE_SR_EXIT:     kind_o = CMD_SR_EXIT;
				CODE_MASK_WRITE:  kind_o = CMD_MASK_WRITE;
				CODE_READ:        kind_o = CMD_READ;
				CODE_COLUMN:      kind_o = CMD_COLUMN;
				CODE_MODE_WRITE1: kind_o = CMD_MODE_WRITE1;
				CODE_MODE_WRITE2: kind_o = CMD_MODE_WRITE2;
				CODE_MODE_READ:   kind_o = CMD_MODE_READ;
				default:          kind_o = CMD_UNUSED_CODE;
			endcase
		end
	end

endmodule
`default_nettype wire

// ### hw/bank_select.sv
// one-hot bank selection with an all-bank override
`timescale 1ns/1ns
`default_nettype none
module bank_select #(
	parameter int NUM = dram_cmd_pkg::NUM_BANKS
) (
	input  wire logic [dram_cmd_pkg::BANK_W-1:0] index_i, // addressed bank
	input  wire logic                            every_i, // all banks
	output var  logic [NUM-1:0]                  mask_o   // banks affected
);
	import dram_cmd_pkg::*;

	genvar g;
	generate
		for (g = 0; g < NUM; g++) begin : g_bank
			assign mask_o[g] = every_i || (index_i == BANK_W'(g));
		end
	endgenerate

endmodule
`default_nettype wire

// ### hw/dram_command_decoder.sv
// command decoder of a low-power dram channel
`timescale 1ns/1ns
`default_nettype none
module dram_command_decoder #(
	parameter logic [6:0] MULTI_NOP_CODE    = 7'h00,
	parameter logic [6:0] MULTI_COL_FIRST   = 7'h01,
	parameter logic [6:0] MULTI_COL_LAST    = 7'h03,
	parameter logic [6:0] MULTI_GUARD_FIRST = 7'h04,
	parameter logic [6:0] MULTI_GUARD_LAST  = 7'h07
) (
	input  wire logic                     clk_i,                   // command clock
	input  wire logic                     srst_i,                  // sync reset, high
	input  wire logic                     chip_select_i,           // chip select
	input  wire logic [5:0]               command_address_lines_i, // command lines
	input  wire logic                     otf_burst_en_i,          // on-the-fly burst on
	input  wire logic                     burst32_default_i,       // burst 32 when otf off
	output var  logic                     cmd_valid_o,             // decoded pulse
	output var  dram_cmd_pkg::decoded_type cmd_o,                  // decoded command
	output var  logic                     illegal_o                // sticky illegal
);
	import dram_cmd_pkg::*;

	// ----------------------------------------------------------------
	// state and helpers
	// ----------------------------------------------------------------
	state_type            s_r;
	state_type            s_nxt;
	cmd_kind_type         kind_w;
	logic [NUM_BANKS-1:0] mask_w;
	logic                 every_w;
	logic [5:0]           lines;
	logic [CODE_W-1:0]    opcode;
	logic                 bad;
	logic                 emit;
	logic                 needs;
	logic                 fulfills;
	decoded_type          rec;

	assign lines   = command_address_lines_i;
	assign opcode  = {s_r.first_lines[5], lines};
	assign every_w = ((kind_w == CMD_PRECHARGE) || (kind_w == CMD_REFRESH))
		&& s_r.first_lines[5];

	cmd_classify u_classify (
		.first_lines_i (s_r.first_lines),
		.kind_o        (kind_w)
	);

	bank_select #(
		.NUM (NUM_BANKS)
	) u_bank (
		.index_i (lines[2:0]),
		.every_i (every_w),
		.mask_o  (mask_w)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.out_valid = 1'b0;
		bad = 1'b0;
		emit = 1'b0;
		rec = DECODED_RESET;
		needs = (kind_w == CMD_COLUMN) || (kind_w == CMD_ACTIVATE2)
			|| (kind_w == CMD_MODE_WRITE2);
		fulfills = ((s_r.wait_for == WAIT_COLUMN) && (kind_w == CMD_COLUMN))
			|| ((s_r.wait_for == WAIT_ACT2) && (kind_w == CMD_ACTIVATE2))
			|| ((s_r.wait_for == WAIT_MODE2) && (kind_w == CMD_MODE_WRITE2));
		case (s_r.phase)
			PH_FIRST: begin
				if (chip_select_i) begin
					s_nxt.first_lines = lines;
					s_nxt.phase = PH_SECOND;
				end else begin
					// deselect: lines ignored, breaks adjacency
					if (s_r.wait_for != WAIT_NONE) begin
						bad = 1'b1;
					end
					if (s_r.guard_left != 2'h0) begin
						s_nxt.guard_left = s_r.guard_left - 2'h1;
					end
				end
			end
			PH_SECOND: begin
				s_nxt.phase = PH_FIRST;
				s_nxt.wait_for = WAIT_NONE;
				if (chip_select_i) begin
					bad = 1'b1;
				end
				if (((s_r.wait_for != WAIT_NONE) || needs) && !fulfills) begin
					bad = 1'b1;
				end
				if (s_r.guard_left != 2'h0) begin
					if ((kind_w == CMD_MULTI) && (opcode == MULTI_NOP_CODE)) begin
						s_nxt.guard_left = s_r.guard_left - 2'h1;
					end else begin
						bad = 1'b1;
					end
				end
				rec.kind = kind_w;
				rec.target_group_index = lines[2:0];
				rec.bank_mask = mask_w;
				case (kind_w)
					CMD_MULTI: begin
						rec.payload_bits = {1'b0, opcode};
						if ((opcode >= MULTI_COL_FIRST) && (opcode <= MULTI_COL_LAST)) begin
							s_nxt.pend = rec;
							s_nxt.wait_for = WAIT_COLUMN;
						end else begin
							emit = 1'b1;
							if ((opcode >= MULTI_GUARD_FIRST)
								&& (opcode <= MULTI_GUARD_LAST)) begin
								s_nxt.guard_left = GUARD_SLOTS;
							end
						end
						rec.target_group_index = '0;
						rec.bank_mask = '0;
						s_nxt.pend.target_group_index = '0;
						s_nxt.pend.bank_mask = '0;
					end
					CMD_PRECHARGE, CMD_REFRESH: begin
						rec.every_bank_flag = s_r.first_lines[5];
						emit = 1'b1;
					end
					CMD_SR_ENTER, CMD_SR_EXIT: begin
						rec.target_group_index = '0;
						rec.bank_mask = '0;
						emit = 1'b1;
					end
					CMD_WRITE, CMD_MASK_WRITE, CMD_READ: begin
						rec.column[9] = lines[4];
						rec.auto_close_flag = lines[5];
						if (kind_w == CMD_MASK_WRITE) begin
							rec.burst_size_flag = 1'b0;
							if (s_r.first_lines[5]) begin
								bad = 1'b1;
							end
						end else if (otf_burst_en_i) begin
							rec.burst_size_flag = s_r.first_lines[5];
						end else begin
							rec.burst_size_flag = burst32_default_i;
						end
						s_nxt.pend = rec;
						s_nxt.wait_for = WAIT_COLUMN;
					end
					CMD_MODE_READ: begin
						rec.reg_index_bits = lines;
						rec.target_group_index = '0;
						rec.bank_mask = '0;
						s_nxt.pend = rec;
						s_nxt.wait_for = WAIT_COLUMN;
					end
					CMD_COLUMN: begin
						rec = s_r.pend;
						// lowest two column bits never sent
						rec.column = {s_r.pend.column[9], s_r.first_lines[5], lines, 2'b00};
						if (((s_r.pend.kind == CMD_WRITE) || (s_r.pend.kind == CMD_MASK_WRITE))
							&& (lines[1:0] != 2'b00)) begin
							bad = 1'b1;
						end
						emit = 1'b1;
					end
					CMD_MODE_WRITE1: begin
						rec.reg_index_bits = lines;
						rec.payload_bits = {s_r.first_lines[5], 7'h00};
						rec.target_group_index = '0;
						rec.bank_mask = '0;
						s_nxt.pend = rec;
						s_nxt.wait_for = WAIT_MODE2;
					end
					CMD_MODE_WRITE2: begin
						rec = s_r.pend;
						rec.payload_bits = {s_r.pend.payload_bits[7], s_r.first_lines[5], lines};
						emit = 1'b1;
					end
					CMD_ACTIVATE1: begin
						rec.row_bits = {s_r.first_lines[5:2], lines[5:4], 10'h000};
						s_nxt.pend = rec;
						s_nxt.wait_for = WAIT_ACT2;
					end
					CMD_ACTIVATE2: begin
						rec = s_r.pend;
						rec.kind = CMD_ACTIVATE2;
						rec.row_bits = {s_r.pend.row_bits[15:10], s_r.first_lines[5:2], lines};
						emit = 1'b1;
					end
					default: begin
						bad = 1'b1;
					end
				endcase
			end
			default: begin
				s_nxt.phase = PH_FIRST;
			end
		endcase
		if (bad) begin
			s_nxt.illegal = 1'b1;
		end
		if (emit && !bad && !s_r.illegal) begin
			s_nxt.out_valid = 1'b1;
			s_nxt.out = rec;
		end
	end

	// ----------------------------------------------------------------
	// registers and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_r <= STATE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cmd_valid_o = s_r.out_valid;
	assign cmd_o       = s_r.out;
	assign illegal_o   = s_r.illegal;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_illegal_sticky: assert property (@(posedge clk_i) disable iff (srst_i)
		illegal_o |=> illegal_o)
		else $error("illegal flag dropped without reset");

	a_two_edge_cmd: assert property (@(posedge clk_i) disable iff (srst_i)
		cmd_valid_o |-> ($past(chip_select_i, 2) && !$past(chip_select_i)))
		else $error("decoded command without high then low select");

	a_deselect_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
		((s_r.phase == PH_FIRST) && !chip_select_i) |=> !cmd_valid_o)
		else $error("deselect produced a command");

	a_every_bank: assert property (@(posedge clk_i) disable iff (srst_i)
		(cmd_valid_o && cmd_o.every_bank_flag) |-> (cmd_o.bank_mask == 8'hFF))
		else $error("all-bank command missing a bank");

	a_one_bank: assert property (@(posedge clk_i) disable iff (srst_i)
		(cmd_valid_o && !cmd_o.every_bank_flag && (cmd_o.kind == CMD_PRECHARGE))
		|-> (cmd_o.bank_mask == (8'h01 << cmd_o.target_group_index)))
		else $error("per-bank mask does not match bank bits");

	a_col_low_zero: assert property (@(posedge clk_i) disable iff (srst_i)
		(cmd_valid_o && ((cmd_o.kind == CMD_WRITE) || (cmd_o.kind == CMD_READ)
		|| (cmd_o.kind == CMD_MODE_READ))) |-> (cmd_o.column[1:0] == 2'b00))
		else $error("low column bits not zero");

	a_mask_burst16: assert property (@(posedge clk_i) disable iff (srst_i)
		(cmd_valid_o && (cmd_o.kind == CMD_MASK_WRITE)) |-> !cmd_o.burst_size_flag)
		else $error("masked write with burst 32");

	a_unused_illegal: assert property (@(posedge clk_i) disable iff (srst_i)
		((s_r.phase == PH_SECOND) && (kind_w == CMD_UNUSED_CODE)) |=> illegal_o)
		else $error("unused code not flagged");

	a_orphan_column: assert property (@(posedge clk_i) disable iff (srst_i)
		((s_r.phase == PH_SECOND) && (kind_w == CMD_COLUMN)
		&& (s_r.wait_for != WAIT_COLUMN)) |=> (illegal_o && !cmd_valid_o))
		else $error("column half without first half accepted");

	a_guard_slots: assert property (@(posedge clk_i) disable iff (srst_i)
		((s_r.phase == PH_SECOND) && (kind_w == CMD_MULTI) && !chip_select_i
		&& (s_r.guard_left == 2'h0) && (opcode >= MULTI_GUARD_FIRST)
		&& (opcode <= MULTI_GUARD_LAST)) |=> (s_r.guard_left == 2'h2))
		else $error("guard slots not armed");

	a_guard_block: assert property (@(posedge clk_i) disable iff (srst_i)
		((s_r.phase == PH_SECOND) && (s_r.guard_left != 2'h0)
		&& !((kind_w == CMD_MULTI) && (opcode == MULTI_NOP_CODE))) |=> illegal_o)
		else $error("command accepted inside guard slots");

	a_second_select: assert property (@(posedge clk_i) disable iff (srst_i)
		((s_r.phase == PH_SECOND) && chip_select_i) |=> (illegal_o && !cmd_valid_o))
		else $error("select high on second edge accepted");

	a_pair_break: assert property (@(posedge clk_i) disable iff (srst_i)
		((s_r.phase == PH_FIRST) && !chip_select_i && (s_r.wait_for != WAIT_NONE))
		|=> illegal_o)
		else $error("deselect inside a command pair accepted");

	a_quiet_after_bad: assert property (@(posedge clk_i) disable iff (srst_i)
		illegal_o |=> !cmd_valid_o)
		else $error("command decoded after illegal event");

endmodule
`default_nettype wire

// ### verif/ctrl_model.sv
// controller model driving select and command lines
`timescale 1ns/1ns
`default_nettype none
module ctrl_model (
	input  wire logic       clk_i,         // command clock
	output var  logic       chip_select_o, // chip select
	output var  logic [5:0] lines_o        // command lines
);
	initial begin
		chip_select_o = 1'b0;
		lines_o       = 6'h00;
	end

	// one edge slot, driven off the falling edge
	task automatic half(input logic sel, input logic [5:0] lines);
		@(negedge clk_i);
		chip_select_o <= sel;
		lines_o       <= lines;
	endtask

	// deselect: lines float, shown as the inverse of the last value
	task automatic idle();
		@(negedge clk_i);
		chip_select_o <= 1'b0;
		lines_o       <= ~lines_o;
	endtask

	// two-edge command, select high then low
	task automatic cmd(input logic [5:0] first, input logic [5:0] second);
		half(1'b1, first);
		half(1'b0, second);
	endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench of the command decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import dram_cmd_pkg::*;
	logic        clk_i;
	logic        srst_i;
	logic        otf_i;
	logic        b32_i;
	logic        cs;
	logic [5:0]  ca;
	logic        cmd_valid_o;
	logic        illegal_o;
	decoded_type cmd_o;
	decoded_type got;
	logic        seen;
	int          bad_count;
	int          cmp_count;

	// ----------------------------------------------------------------
	// parts
	// ----------------------------------------------------------------
	ctrl_model drv_u (.clk_i(clk_i), .chip_select_o(cs), .lines_o(ca));
	dram_command_decoder dut_u (
		.clk_i(clk_i), .srst_i(srst_i), .chip_select_i(cs),
		.command_address_lines_i(ca), .otf_burst_en_i(otf_i),
		.burst32_default_i(b32_i), .cmd_valid_o(cmd_valid_o),
		.cmd_o(cmd_o), .illegal_o(illegal_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic settle();
		seen = 1'b0;
		repeat (4) begin
			drv_u.idle();
			if (cmd_valid_o === 1'b1 && seen === 1'b0) begin
				seen = 1'b1;
				got  = cmd_o;
			end
		end
	endtask

	task automatic do_reset();
		@(negedge clk_i);
		srst_i <= 1'b1;
		repeat (20) @(negedge clk_i);
		srst_i <= 1'b0;
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_bank();
		settle();
		check(seen === 1'b0, "deselect gave a pulse");
		for (int i = 0; i < 8; i++) begin
			drv_u.cmd(6'h10, 6'(i));
			settle();
			check(seen === 1'b1 && got.kind === CMD_PRECHARGE, "precharge kind");
			check(got.bank_mask === 8'(1 << i), "precharge bank mask");
		end
		drv_u.cmd(6'h28, 6'h03);
		settle();
		check(seen === 1'b1 && got.kind === CMD_REFRESH, "refresh kind");
		check(got.bank_mask === 8'hFF && got.every_bank_flag === 1'b1, "all banks");
		drv_u.cmd(6'h30, 6'h02);
		settle();
		check(seen === 1'b1 && got.bank_mask === 8'hFF, "precharge all");
	endtask

	task automatic t_column();
		otf_i <= 1'b1;
		drv_u.cmd(6'h22, 6'h35);
		drv_u.cmd(6'h32, 6'h2A);
		settle();
		check(seen === 1'b1 && got.kind === CMD_READ, "read kind");
		check(got.burst_size_flag === 1'b1 && got.auto_close_flag === 1'b1, "read flags");
		check(got.column === 10'h3A8 && got.target_group_index === 3'h5, "read column");
		drv_u.cmd(6'h02, 6'h01);
		drv_u.cmd(6'h12, 6'h00);
		settle();
		check(seen === 1'b1 && got.burst_size_flag === 1'b0, "read burst 16");
		otf_i <= 1'b0;
		b32_i <= 1'b1;
		drv_u.cmd(6'h04, 6'h00);
		drv_u.cmd(6'h12, 6'h3C);
		settle();
		check(seen === 1'b1 && got.kind === CMD_WRITE, "write kind");
		check(got.burst_size_flag === 1'b1 && got.column === 10'h0F0, "write fields");
		check(got.auto_close_flag === 1'b0, "write auto close");
		drv_u.cmd(6'h0C, 6'h02);
		drv_u.cmd(6'h12, 6'h00);
		settle();
		check(seen === 1'b1 && got.kind === CMD_MASK_WRITE, "masked write kind");
		check(got.burst_size_flag === 1'b0 && got.target_group_index === 3'h2, "mask fields");
		drv_u.cmd(6'h0E, 6'h11);
		drv_u.cmd(6'h12, 6'h00);
		settle();
		check(seen === 1'b1 && got.kind === CMD_MODE_READ, "readback kind");
		check(got.reg_index_bits === 6'h11, "readback index");
		drv_u.cmd(6'h00, 6'h01);
		drv_u.cmd(6'h12, 6'h05);
		settle();
		check(seen === 1'b1 && got.kind === CMD_MULTI, "column multipurpose kind");
		check(got.column === 10'h014 && got.payload_bits === 8'h01, "multi column");
	endtask

	task automatic t_row();
		drv_u.cmd(6'h29, 6'h27);
		drv_u.cmd(6'h17, 6'h33);
		settle();
		check(seen === 1'b1 && got.kind === CMD_ACTIVATE2, "activate kind");
		check(got.row_bits === 16'hA973 && got.target_group_index === 3'h7, "row");
		drv_u.cmd(6'h26, 6'h2D);
		drv_u.cmd(6'h16, 6'h15);
		settle();
		check(seen === 1'b1 && got.payload_bits === 8'h95, "mode write payload");
		check(got.reg_index_bits === 6'h2D, "mode write index");
		drv_u.cmd(6'h20, 6'h00);
		settle();
		check(seen === 1'b1 && got.kind === CMD_MULTI, "multi kind");
		check(got.payload_bits === 8'h40, "multi payload");
		drv_u.cmd(6'h38, 6'h3F);
		settle();
		check(seen === 1'b1 && got.kind === CMD_SR_ENTER, "self refresh entry");
		drv_u.cmd(6'h14, 6'h2A);
		settle();
		check(seen === 1'b1 && got.kind === CMD_SR_EXIT, "self refresh exit");
		drv_u.cmd(6'h00, 6'h04);
		settle();
		drv_u.cmd(6'h10, 6'h01);
		settle();
		check(seen === 1'b1 && illegal_o === 1'b0, "command after idle slots");
		drv_u.cmd(6'h00, 6'h07);
		drv_u.idle();
		drv_u.cmd(6'h00, 6'h00);
		drv_u.cmd(6'h10, 6'h01);
		settle();
		check(seen === 1'b1 && got.kind === CMD_PRECHARGE, "command after nop slot");
		check(illegal_o === 1'b0, "deselect and nop slots refused");
	endtask

	task automatic run_bad(input logic [5:0] f1, input logic sel_b, input logic [5:0] s1,
			input logic sel_c, input logic [5:0] f2, input logic [5:0] s2);
		drv_u.half(1'b1, f1);
		drv_u.half(sel_b, s1);
		drv_u.half(sel_c, f2);
		drv_u.half(1'b0, s2);
		settle();
		check(illegal_o === 1'b1, "illegal flag not set");
		drv_u.cmd(6'h10, 6'h01);
		settle();
		check(seen === 1'b0 && illegal_o === 1'b1, "decoding after illegal");
		do_reset();
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		bad_count = 0;
		cmp_count = 0;
		srst_i    = 1'b1;
		otf_i     = 1'b0;
		b32_i     = 1'b0;
		repeat (20) @(negedge clk_i);
		srst_i <= 1'b0;
		t_bank();
		t_column();
		t_row();
		run_bad(6'h1C, 1'b0, 6'h00, 1'b0, 6'h00, 6'h00);
		run_bad(6'h12, 1'b0, 6'h00, 1'b0, 6'h00, 6'h00);
		run_bad(6'h10, 1'b1, 6'h10, 1'b0, 6'h00, 6'h00);
		run_bad(6'h00, 1'b0, 6'h04, 1'b1, 6'h10, 6'h03);
		run_bad(6'h2C, 1'b0, 6'h00, 1'b1, 6'h12, 6'h00);
		run_bad(6'h02, 1'b0, 6'h00, 1'b0, 6'h00, 6'h00);
		run_bad(6'h04, 1'b0, 6'h00, 1'b1, 6'h12, 6'h03);
		run_bad(6'h01, 1'b0, 6'h00, 1'b1, 6'h01, 6'h00);
		run_bad(6'h06, 1'b0, 6'h00, 1'b0, 6'h00, 6'h00);
		run_bad(6'h0E, 1'b0, 6'h00, 1'b0, 6'h00, 6'h00);
		summarize();
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		bad_count++;
		summarize();
	end
endmodule
`default_nettype wire
